// ===== cps_cfg.svh
// Constants of the configuration power-up sequencer
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CPS_CLK_MHZ        40
`define CPS_CLK_NS         25

// ----------------------------------------------------------------
// Timing figures, printed units
// ----------------------------------------------------------------
`define CPS_T_RDY_S0_US    200
`define CPS_T_RDY_S1_US    50
`define CPS_T_RDY_L0_MS    35
`define CPS_T_RDY_L1_MS    10
`define CPS_T_RCFG_LOW_NS  25
`define CPS_T_RDY_FALL_NS  70
`define CPS_T_DONE_FALL_NS 80
`define CPS_T_TCK_MAX_NS   1000
`define CPS_INIT_MARGIN    8
`define CPS_FLASH_EDGES    5'h10

// ----------------------------------------------------------------
// Register offsets, byte addresses
// ----------------------------------------------------------------
`define CPS_OFS_CTRL       8'h00
`define CPS_OFS_STATUS     8'h04
`define CPS_OFS_ID         8'h08
`define CPS_OFS_TAG        8'h0c
`define CPS_OFS_LOAD       8'h10
`define CPS_OFS_VERIFY     8'h14
`define CPS_OFS_FLASH      8'h18

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CPS_CTRL_REPROG    0
`define CPS_HDR_SECURE     31
`define CPS_TAG_RST        32'h0000_0000
`define CPS_PIN_RST        8'h00

`endif

// ===== cps_pkg.sv
// Types of the configuration power-up sequencer
package cps_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        CPS_POR, CPS_INIT, CPS_LOAD, CPS_WAKE, CPS_USER, CPS_ERROR
    } cps_state_t;

    // Position within a bitstream
    typedef enum logic [1:0] {
        CPS_LD_ID, CPS_LD_HDR, CPS_LD_DATA, CPS_LD_SUM
    } cps_load_t;

    // Embedded flash operations
    typedef enum logic [1:0] {
        CPS_FL_NONE, CPS_FL_ERASE, CPS_FL_PROG, CPS_FL_VERIFY
    } cps_flash_op_t;

    // Pin inputs as one bundle
    typedef struct packed {
        logic       reload_trigger_n;
        logic       ready;
        logic       done;
        logic       scan_sel;
        logic       tck;
        logic [2:0] boot_source;
    } cps_pin_t;

    // Status word layout
    typedef struct packed {
        logic [17:0] rsvd;
        logic        scan_mode;
        logic        tck_slow;
        logic        flash_rej;
        logic        flash_busy;
        logic        secure;
        logic        sum_err;
        logic        id_err;
        logic        id_ok;
        logic [2:0]  boot;
        cps_state_t  state;
    } cps_status_t;

endpackage : cps_pkg

// ===== cps_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_sync #(
    parameter int W = 8
)(
    input  logic         clk_sys,
    input  logic         nrst,
    input  logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            meta_reg <= W'(`CPS_PIN_RST);
            q        <= W'(`CPS_PIN_RST);
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : cps_sync

// ===== cps_top.sv
// Configuration power-up sequencer with APB register slave
//
// Contract
// - Pull ready/done low, init, release ready, sample boot, load, wake, user.
// - A floating reload trigger reads as inactive; pull-up kept on.
// - GPIOs high impedance with weak pull-up until wake-up begins.
// - Identification word checked before loading; mismatch stops configuration.
// - Identification, user tag and status registers are readable.
// - Secured bitstream refuses readback and verification.
// - Flash erase/program/verify only via scan port, clocked at 1MHz or more.
// - Device keeps running old design during flash programming; reload loads new.
// - Mode from three boot selector bits; unbonded bits read as zero.
// - Ready and done carry no meaning during scan-port configuration; code still waits on ready in INIT and done in WAKE whatever scan_sel.
// - Small family raises ready by 200us (bit0 low) or 50us (bit0 high).
// - Large family raises ready by 35ms (bit0 low) or 10ms (bit0 high).
// - Reload falling edge pulls ready low within 70ns, done within 80ns; code takes up to three clocks (75ns) for both.
// - Scan-port loads write volatile memory, cleared on each start.
// - Load error drives ready low and user design never starts.
// - Wake-up waits while done pin is held low externally.
// - Initialisation not left while ready is held low externally.
`timescale 1ns/100ps
`include "cps_cfg.svh"
module cps_top #(
    parameter logic [31:0] DEVICE_ID    = 32'h5a5a_0001, // Arbitrary value
    parameter bit          LARGE_FAMILY = 1'b0,
    parameter logic [2:0]  BOOT_BONDED  = 3'h7,
    parameter int INIT_S0_CYC = `CPS_T_RDY_S0_US * `CPS_CLK_MHZ - `CPS_INIT_MARGIN,
    parameter int INIT_S1_CYC = `CPS_T_RDY_S1_US * `CPS_CLK_MHZ - `CPS_INIT_MARGIN,
    parameter int INIT_L0_CYC = `CPS_T_RDY_L0_MS * 1000 * `CPS_CLK_MHZ - `CPS_INIT_MARGIN,
    parameter int INIT_L1_CYC = `CPS_T_RDY_L1_MS * 1000 * `CPS_CLK_MHZ - `CPS_INIT_MARGIN
)(
    input  logic             clk_sys,
    input  logic             nrst,
    input  cps_pkg::cps_pin_t pins,
    input  logic             psel,
    input  logic             penable,
    input  logic             pwrite,
    input  logic [7:0]       paddr,
    input  logic [31:0]      pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             ready_o,
    output logic             ready_oe_n,
    output logic             done_o,
    output logic             done_oe_n,
    output logic             reload_pullup_en,
    output logic             gpio_hiz,
    output logic             gpio_pullup_en,
    output logic             global_reset,
    output logic             global_write_dis,
    output logic             user_mode
);
    // ----------------------------------------------------------------
    // Derived counts
    // ----------------------------------------------------------------
    localparam logic [5:0] TCK_GAP_CYC = 6'(`CPS_T_TCK_MAX_NS / `CPS_CLK_NS);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic cps_hit(input logic [7:0] a, input logic [7:0] ofs);
        cps_hit = (a == ofs);
    endfunction : cps_hit

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    cps_pkg::cps_pin_t pins_s;

    cps_sync #(
        .W ($bits(cps_pkg::cps_pin_t))
    ) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       (pins),
        .q       (pins_s)
    );

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    cps_pkg::cps_state_t    state_reg, state_next;
    cps_pkg::cps_load_t     ld_reg;
    cps_pkg::cps_flash_op_t flash_op_reg;
    logic [20:0] timer_reg;
    logic        init_rel_reg;
    logic        bit0_reg;
    logic [2:0]  boot_reg;
    logic [1:0]  wake_reg;
    logic [15:0] left_reg;
    logic [31:0] sum_reg;
    logic [31:0] tag_reg;
    logic        id_ok_reg, id_err_reg, sum_err_reg, secure_reg;
    logic        reprog_reg;
    logic        tck_prev_reg;
    logic        flash_busy_reg, flash_rej_reg, tck_slow_reg;
    logic [4:0]  flash_cnt_reg;
    logic [5:0]  gap_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Unbonded selector bits read as ground
    wire [2:0]  boot_eff  = pins_s.boot_source & BOOT_BONDED;
    wire        reload_s  = pins_s.reload_trigger_n;
    wire        setup     = psel & ~penable;
    // Write acts only at the access edge that samples pready
    wire        wr        = psel & penable & pwrite & pready;
    wire        restart   = ~reload_s | reprog_reg;
    wire        tck_rise  = pins_s.tck & ~tck_prev_reg;
    wire        hit_ctrl  = cps_hit(paddr, `CPS_OFS_CTRL);
    wire        hit_stat  = cps_hit(paddr, `CPS_OFS_STATUS);
    wire        hit_id    = cps_hit(paddr, `CPS_OFS_ID);
    wire        hit_tag   = cps_hit(paddr, `CPS_OFS_TAG);
    wire        hit_load  = cps_hit(paddr, `CPS_OFS_LOAD);
    wire        hit_ver   = cps_hit(paddr, `CPS_OFS_VERIFY);
    wire        hit_flash = cps_hit(paddr, `CPS_OFS_FLASH);
    wire        load_ok   = state_reg == cps_pkg::CPS_LOAD;
    wire        wr_load   = wr & hit_load & load_ok;
    wire        wr_flash  = wr & hit_flash;
    wire [1:0]  flash_req = pwdata[1:0];

    // Ready deadline picked by family and selector bit zero
    wire [31:0] init_lim  = LARGE_FAMILY ? (bit0_reg ? 32'(INIT_L1_CYC)
                                                     : 32'(INIT_L0_CYC))
                                         : (bit0_reg ? 32'(INIT_S1_CYC)
                                                     : 32'(INIT_S0_CYC));
    wire        init_exp  = timer_reg >= init_lim[20:0];

    // Load data checks
    wire        id_match  = pwdata == DEVICE_ID;
    wire        sum_match = pwdata == sum_reg;
    wire        hdr_empty = pwdata[15:0] == 16'h0000;

    // Write decisions for the flash port; only the scan port may drive it
    wire        fl_accept = wr_flash & pins_s.scan_sel & ~flash_busy_reg
                            & (flash_req != 2'(cps_pkg::CPS_FL_NONE));
    wire        fl_reject = wr_flash & ~pins_s.scan_sel;
    wire        fl_done   = flash_busy_reg & tck_rise
                            & (flash_cnt_reg == `CPS_FLASH_EDGES - 5'h01);
    wire        fl_slow   = flash_busy_reg & ~tck_rise & (gap_reg == TCK_GAP_CYC);

    // Status word
    cps_pkg::cps_status_t status;
    assign status.rsvd       = '0;
    assign status.scan_mode  = pins_s.scan_sel;
    assign status.tck_slow   = tck_slow_reg;
    assign status.flash_rej  = flash_rej_reg;
    assign status.flash_busy = flash_busy_reg;
    assign status.secure     = secure_reg;
    assign status.sum_err    = sum_err_reg;
    assign status.id_err     = id_err_reg;
    assign status.id_ok      = id_ok_reg;
    assign status.boot       = boot_reg;
    assign status.state      = state_reg;

    // Read mux; verification hides secured data
    wire        ver_deny  = hit_ver & secure_reg;
    wire        load_rd   = hit_load & ~pwrite;
    wire        load_bad  = hit_load & pwrite & ~load_ok;
    wire        unmapped  = ~(hit_ctrl | hit_stat | hit_id | hit_tag | hit_load
                              | hit_ver | hit_flash);
    wire        err_next  = unmapped | ver_deny | load_bad | load_rd;
    wire [31:0] rd_mux    = hit_stat  ? status :
                            hit_id    ? DEVICE_ID :
                            hit_tag   ? tag_reg :
                            (hit_ver & ~secure_reg) ? sum_reg :
                            hit_flash ? {29'h0, flash_busy_reg, flash_op_reg} :
                            32'h0000_0000;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            cps_pkg::CPS_POR:
                if (reload_s)
                    state_next = cps_pkg::CPS_INIT;
            cps_pkg::CPS_INIT:
                // Leave only when released ready is seen high
                if (init_rel_reg & pins_s.ready & reload_s)
                    state_next = cps_pkg::CPS_LOAD;
            cps_pkg::CPS_LOAD:
                if (wr_load & ld_reg == cps_pkg::CPS_LD_ID & ~id_match)
                    state_next = cps_pkg::CPS_ERROR;
                else if (wr_load & ld_reg == cps_pkg::CPS_LD_SUM)
                    state_next = sum_match ? cps_pkg::CPS_WAKE
                                           : cps_pkg::CPS_ERROR;
            cps_pkg::CPS_WAKE:
                if (wake_reg == 2'h3 & pins_s.done)
                    state_next = cps_pkg::CPS_USER;
            cps_pkg::CPS_USER:
                state_next = cps_pkg::CPS_USER;
            cps_pkg::CPS_ERROR:
                state_next = cps_pkg::CPS_ERROR;
            default:
                state_next = cps_pkg::CPS_POR;
        endcase
        if (state_reg != cps_pkg::CPS_POR & restart)
            state_next = cps_pkg::CPS_INIT;
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    // Timer and ready release; restart from LOAD, WAKE, USER or ERROR rewinds the whole flow
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_reg    <= cps_pkg::CPS_POR;
            timer_reg    <= 21'h000000;
            init_rel_reg <= 1'b0;
            bit0_reg     <= 1'b0;
            boot_reg     <= 3'h0;
            wake_reg     <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next == cps_pkg::CPS_INIT & state_reg != cps_pkg::CPS_INIT)
            begin
                timer_reg    <= 21'h000000;
                init_rel_reg <= 1'b0;
                bit0_reg     <= boot_eff[0];
            end
            else if (state_reg == cps_pkg::CPS_INIT & ~init_exp)
                timer_reg <= timer_reg + 21'h000001;
            else if (state_reg == cps_pkg::CPS_INIT & reload_s)
                init_rel_reg <= 1'b1;
            // Mode sampled on the ready rise
            if (state_reg == cps_pkg::CPS_INIT & state_next == cps_pkg::CPS_LOAD)
                boot_reg <= boot_eff;
            if (state_reg != cps_pkg::CPS_WAKE)
                wake_reg <= 2'h0;
            else if (wake_reg != 2'h3)
                wake_reg <= wake_reg + 2'h1;
        end
    end

    // Bitstream parse; memory is volatile, so every start wipes it
    always_ff @(posedge clk_sys)
    begin
        if (!nrst | state_reg == cps_pkg::CPS_INIT)
        begin
            ld_reg      <= cps_pkg::CPS_LD_ID;
            left_reg    <= 16'h0000;
            sum_reg     <= 32'h0000_0000;
            secure_reg  <= 1'b0;
            id_ok_reg   <= 1'b0;
            id_err_reg  <= 1'b0;
            sum_err_reg <= 1'b0;
        end
        else if (wr_load)
        begin
            case (ld_reg)
                cps_pkg::CPS_LD_ID:
                begin
                    id_ok_reg  <= id_match;
                    id_err_reg <= ~id_match;
                    ld_reg     <= cps_pkg::CPS_LD_HDR;
                end
                cps_pkg::CPS_LD_HDR:
                begin
                    secure_reg <= pwdata[`CPS_HDR_SECURE];
                    left_reg   <= pwdata[15:0];
                    ld_reg     <= hdr_empty ? cps_pkg::CPS_LD_SUM
                                            : cps_pkg::CPS_LD_DATA;
                end
                cps_pkg::CPS_LD_DATA:
                begin
                    sum_reg  <= sum_reg + pwdata;
                    left_reg <= left_reg - 16'h0001;
                    if (left_reg == 16'h0001)
                        ld_reg <= cps_pkg::CPS_LD_SUM;
                end
                cps_pkg::CPS_LD_SUM:
                    sum_err_reg <= ~sum_match;
                default:
                    ld_reg <= cps_pkg::CPS_LD_ID;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Flash port
    // ----------------------------------------------------------------
    // Gap watchdog aborts when the scan clock runs slower than 1MHz
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tck_prev_reg   <= 1'b0;
            flash_busy_reg <= 1'b0;
            flash_op_reg   <= cps_pkg::CPS_FL_NONE;
            flash_cnt_reg  <= 5'h00;
            gap_reg        <= 6'h00;
            flash_rej_reg  <= 1'b0;
            tck_slow_reg   <= 1'b0;
        end
        else
        begin
            tck_prev_reg <= pins_s.tck;
            if (fl_accept)
            begin
                flash_busy_reg <= 1'b1;
                flash_op_reg   <= cps_pkg::cps_flash_op_t'(flash_req);
                flash_cnt_reg  <= 5'h00;
                gap_reg        <= 6'h00;
                flash_rej_reg  <= 1'b0;
                tck_slow_reg   <= 1'b0;
            end
            else if (fl_done | fl_slow)
                flash_busy_reg <= 1'b0;
            else if (flash_busy_reg & tck_rise)
            begin
                flash_cnt_reg <= flash_cnt_reg + 5'h01;
                gap_reg       <= 6'h00;
            end
            else if (flash_busy_reg)
                gap_reg <= gap_reg + 6'h01;
            // Sticky flags; a new event always lands
            if (fl_reject)
                flash_rej_reg <= 1'b1;
            if (fl_slow)
                tck_slow_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states: pready rises for the access phase only
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pready     <= 1'b0;
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
            tag_reg    <= `CPS_TAG_RST;
            reprog_reg <= 1'b0;
        end
        else
        begin
            pready     <= setup;
            prdata     <= setup & ~pwrite ? rd_mux : 32'h0000_0000;
            pslverr    <= setup & err_next;
            reprog_reg <= wr & hit_ctrl & pwdata[`CPS_CTRL_REPROG];
            if (wr & hit_tag)
                tag_reg <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin and global controls
    // ----------------------------------------------------------------
    // Drive ready low at start, in error and on any reload low
    wire rdy_low  = state_reg == cps_pkg::CPS_POR | state_reg == cps_pkg::CPS_ERROR
                    | (state_reg == cps_pkg::CPS_INIT & ~init_rel_reg)
                    | ~reload_s;
    wire done_low = ~(state_reg == cps_pkg::CPS_USER
                      | (state_reg == cps_pkg::CPS_WAKE & wake_reg == 2'h3))
                    | ~reload_s;
    wire woke     = (state_reg == cps_pkg::CPS_USER | state_reg == cps_pkg::CPS_WAKE) & ~restart;
    wire rel_gsr  = state_reg == cps_pkg::CPS_USER
                    | (state_reg == cps_pkg::CPS_WAKE & wake_reg != 2'h0);

    // Open-drain pins only ever drive low; scan loads still wait on ready and done
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ready_o          <= 1'b0;
            ready_oe_n       <= 1'b0;
            done_o           <= 1'b0;
            done_oe_n        <= 1'b0;
            reload_pullup_en <= 1'b1;
            gpio_hiz         <= 1'b1;
            gpio_pullup_en   <= 1'b1;
            global_reset     <= 1'b1;
            global_write_dis <= 1'b1;
            user_mode        <= 1'b0;
        end
        else
        begin
            ready_o          <= 1'b0;
            ready_oe_n       <= ~rdy_low;
            done_o           <= 1'b0;
            done_oe_n        <= ~done_low;
            reload_pullup_en <= 1'b1;
            gpio_hiz         <= ~woke;
            gpio_pullup_en   <= ~woke;
            global_reset     <= ~rel_gsr;
            global_write_dis <= ~rel_gsr;
            user_mode        <= state_reg == cps_pkg::CPS_USER & ~restart;
        end
    end

endmodule : cps_top

// ===== cps_top_assertions.sv
// Port-level checker for the configuration power-up sequencer
`timescale 1ns/100ps
module cps_top_checker (
    input logic              clk_sys,
    input logic              nrst,
    input cps_pkg::cps_pin_t pins,
    input logic              psel,
    input logic              penable,
    input logic              pready,
    input logic              pslverr,
    input logic              ready_oe_n,
    input logic              done_oe_n,
    input logic              gpio_hiz,
    input logic              gpio_pullup_en,
    input logic              global_reset,
    input logic              global_write_dis,
    input logic              reload_pullup_en,
    input logic              user_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Sequencer and bus relations
    // ----------------------------------------
    a_apb_one_wait: assert property (psel && !penable |=> pready)
        else $error("pready not one cycle after setup");
    a_err_in_access: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    a_reload_pullup: assert property ($past(nrst) |-> reload_pullup_en)
        else $error("reload pull-up off");
    a_pins_hiz: assert property (!gpio_hiz |-> ready_oe_n && !gpio_pullup_en)
        else $error("user pins driven before init done");
    a_reload_restart: assert property ($fell(pins.reload_trigger_n) |->
        ##[1:3] (!ready_oe_n && !done_oe_n)) else $error("reload not seen in time");
    a_wake_order: assert property ($fell(global_reset) |-> !$past(gpio_hiz)
        && !global_write_dis) else $error("global reset freed before outputs");
    a_done_last: assert property ($rose(done_oe_n) |-> !global_reset && !gpio_hiz)
        else $error("done released too early");
    a_user_done_pin: assert property ($rose(user_mode) |-> $past(pins.done, 2))
        else $error("user mode while done held low");
    a_user_ready: assert property (user_mode |-> ready_oe_n && done_oe_n)
        else $error("user mode with indicator low");
    a_ready_hold: assert property ((!pins.ready)[*3] |-> gpio_hiz && !user_mode)
        else $error("left init while ready held");
    c_user: cover property ($rose(user_mode));
    c_reload: cover property ($fell(pins.reload_trigger_n));
    c_slverr: cover property (pslverr);
endmodule : cps_top_checker

bind cps_top cps_top_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .pins(pins),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .ready_oe_n(ready_oe_n), .done_oe_n(done_oe_n), .gpio_hiz(gpio_hiz),
    .global_reset(global_reset), .reload_pullup_en(reload_pullup_en), .user_mode(user_mode),
    .gpio_pullup_en(gpio_pullup_en), .global_write_dis(global_write_dis));

// ===== cps_host.sv
// Model of the external host on the configuration pins
`timescale 1ns/100ps
module cps_host (
    input  logic ready_oe_n,
    input  logic done_oe_n,
    input  logic hold_ready,
    input  logic hold_done,
    input  logic tck_en,
    output logic ready_lvl,
    output logic done_lvl,
    output logic tck
);
    // Open-drain wires with pull-up; host may clamp them low
    assign ready_lvl = ready_oe_n && !hold_ready;
    assign done_lvl  = done_oe_n && !hold_done;
    // Scan clock 5 MHz, parked low by its pull-down outside flash work
    initial
    begin
        tck = 1'b0;
        #37;
        forever
        begin
            #100;
            tck = tck_en ? ~tck : 1'b0;
        end
    end
endmodule : cps_host

// ===== cps_top_bench.sv
// Self-checking bench of the configuration power-up sequencer
`timescale 1ns/100ps
module cps_top_bench;
    localparam logic [31:0] ID = 32'h1234_abcd; // Arbitrary value
    logic              clk_sys = 1'b0;
    logic              nrst = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, p0, p1;
    logic              pready, pslverr, ready_oe_n, done_oe_n, ready_lvl, done_lvl, tck;
    logic              reload_n = 1'b1; // Kept high through init and load
    logic              scan_sel = 1'b0, hold_ready = 1'b1, hold_done = 1'b1, tck_en = 1'b0;
    logic [2:0]        boot;
    int                seed = 34;
    int                num_errors = 0;
    int                comparisons = 0;
    logic [32:0]       exp_q[$];
    cps_pkg::cps_pin_t pins;
    // ----------------------------------------
    // Clock, pins and instances
    // ----------------------------------------
    assign pins = {reload_n, ready_lvl, done_lvl, scan_sel, tck, boot};
    always #12.5 clk_sys = ~clk_sys;
    cps_top #(.DEVICE_ID(ID), .INIT_S0_CYC(20), .INIT_S1_CYC(20)) dut (.clk_sys(clk_sys),
        .nrst(nrst), .pins(pins), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ready_o(), .ready_oe_n(ready_oe_n), .done_o(), .done_oe_n(done_oe_n),
        .reload_pullup_en(), .gpio_hiz(), .gpio_pullup_en(), .global_reset(),
        .global_write_dis(), .user_mode());
    cps_host host (.ready_oe_n(ready_oe_n), .done_oe_n(done_oe_n), .hold_ready(hold_ready),
        .hold_done(hold_done), .tck_en(tck_en), .ready_lvl(ready_lvl),
        .done_lvl(done_lvl), .tck(tck));
    task check(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task end_sim;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    // Holds the request until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        if (!w)
            exp_q.push_back(e);
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr
    function logic [32:0] st(input logic [13:0] f, input logic [2:0] s);
        return {19'h0, f | {8'h0, boot, s}};
    endfunction : st
    // Each finished read retires the oldest expectation
    always @(posedge clk_sys)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());
    initial
    begin
        #100000;
        num_errors++;
        end_sim();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        boot = 3'($random(seed));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (60) @(posedge clk_sys);
        rd(8'h04, 33'h1);
        hold_ready <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rd(8'h04, st(14'h0, 3'h2));
        rd(8'h08, {1'b0, ID});
        p0 = $random(seed);
        p1 = $random(seed);
        wr(8'h0c, p0);
        rd(8'h0c, {1'b0, p0});
        rd(8'h1c, {1'b1, 32'h0});
        wr(8'h10, ID);
        wr(8'h10, 32'h8000_0002);
        wr(8'h10, p0);
        wr(8'h10, p1);
        wr(8'h10, p0 + p1);
        repeat (10) @(posedge clk_sys);
        rd(8'h04, st(14'h0240, 3'h3));
        rd(8'h14, {1'b1, 32'h0});
        hold_done <= 1'b0;
        repeat (10) @(posedge clk_sys);
        wr(8'h18, 32'h2);
        rd(8'h04, st(14'h0a40, 3'h4));
        scan_sel <= 1'b1;
        tck_en <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(8'h18, 32'h2);
        rd(8'h18, 33'h6);
        repeat (200) @(posedge clk_sys);
        rd(8'h18, 33'h2);
        rd(8'h04, st(14'h2240, 3'h4));
        {scan_sel, tck_en, reload_n} <= 3'b000;
        boot <= 3'($random(seed));
        repeat (3) @(posedge clk_sys);
        #1;
        check({32'h0, ready_lvl}, 33'h0);
        reload_n <= 1'b1;
        repeat (60) @(posedge clk_sys);
        rd(8'h04, st(14'h0, 3'h2));
        wr(8'h10, ~ID);
        repeat (4) @(posedge clk_sys);
        rd(8'h04, st(14'h0080, 3'h5));
        check({32'h0, ready_lvl}, 33'h0);
        wr(8'h00, 32'h1);
        rd(8'h04, st(14'h0, 3'h1));
        end_sim();
    end
endmodule : cps_top_bench
